// ### design/psrc_pkg.sv
// Purpose: Constants for the host controller of the pseudo-static RAM port
// Assumes: 50 MHz system clock, slow speed grade timing
// Notes:   Times in ns, counts derived with rounding per least/longest
package psrc_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // Device timing, slow grade
  localparam int ADDRESS_ACCESS_TIME_NS = 70;
  localparam int OUTPUT_ENABLE_FLOAT_DELAY_NS = 25;
  localparam int DESELECT_FLOAT_DELAY_NS = 25;
  localparam int WRITE_DATA_SETUP_NS = 30;
  localparam int SELECT_TO_WRITE_END_NS = 60;
  localparam int WE_FLOAT_DELAY_NS = 30;
  localparam int DESELECT_MIN_TIME_NS = 5;
  localparam int MAX_SELECT_ACTIVE_TIME_NS = 15000;
  // Least times round up, at least one cycle
  function automatic int up_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  // Read sample one cycle after access time so data has settled
  localparam int READ_CYC = up_cyc(ADDRESS_ACCESS_TIME_NS) + 1;
  // Write pulse covers select-to-end and float plus setup
  localparam int WR_A = up_cyc(SELECT_TO_WRITE_END_NS);
  localparam int WR_B = up_cyc(WE_FLOAT_DELAY_NS + WRITE_DATA_SETUP_NS) + 1;
  localparam int WRITE_CYC = (WR_A > WR_B) ? WR_A : WR_B;
  localparam int FLOAT_CYC = up_cyc(DESELECT_FLOAT_DELAY_NS);
  localparam int DESEL_CYC = up_cyc(DESELECT_MIN_TIME_NS) + 1;
  // Longest selected time rounds down
  localparam int SELECT_MAX_CYC = MAX_SELECT_ACTIVE_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
endpackage

// ### design/psrc_ctrl.sv
// Purpose: Host controller driving an asynchronous pseudo-static RAM
// Assumes: One access per select period, so selects never stay long active
// Notes:   Data bus is three signals; enable high while this side drives
`timescale 1ns/100ps
module psrc_ctrl #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16,
  parameter int SELECT_MAX = psrc_pkg::SELECT_MAX_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_byte_en,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // Memory pins
  output logic [ADDR_W-1:0] word_address,
  output logic select_low_active_n,
  output logic select_high_active,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic upper_byte_select_n,
  output logic lower_byte_select_n,
  input wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0] data_bus_out,
  output logic data_bus_oe
);
  // Lane split needs 16 bits; the select limit must fit the counter
  if (ADDR_W < 1 || DATA_W != 16 ||
      SELECT_MAX <= psrc_pkg::WRITE_CYC + 2 ||
      SELECT_MAX >= (1 << psrc_pkg::CNT_W)) begin : g_param_check
    $error("psrc_ctrl: unsupported parameters");
  end

  typedef enum logic [2:0] {
    PSRC_IDLE, PSRC_READ, PSRC_WRITE, PSRC_FLOAT, PSRC_DESEL
  } psrc_state_t;

  // Two-flop synchroniser for the asynchronous data pins
  logic [DATA_W-1:0] din_s1_q, din_s2_q;
  always_ff @(posedge sys_clk) begin
    din_s1_q <= data_bus_in;
    din_s2_q <= din_s1_q;
  end

  psrc_state_t st_q, st_d;
  logic [psrc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic cs_q, cs_d, oe_q, oe_d, we_q, we_d, ub_q, ub_d, lb_q, lb_d;
  logic doe_q, doe_d, rdy_q, rdy_d, rv_q, rv_d;

  // Next-state logic for the access sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 16'h0001;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    cs_d = cs_q;
    oe_d = oe_q;
    we_d = we_q;
    ub_d = ub_q;
    lb_d = lb_q;
    doe_d = doe_q;
    rdy_d = rdy_q;
    rv_d = 1'b0;
    unique case (st_q)
      PSRC_IDLE: begin
        // Address, byte lanes and select move together: no earlier skew
        if (req_valid && rdy_q) begin
          rdy_d = 1'b0;
          addr_d = req_addr;
          wdat_d = req_wdata;
          cs_d = 1'b1;
          cnt_d = '0;
          ub_d = req_write ? req_byte_en[1] : 1'b1;
          lb_d = req_write ? req_byte_en[0] : 1'b1;
          if (req_write && (req_byte_en != 2'b00)) begin
            we_d = 1'b1;
            st_d = PSRC_WRITE;
          end else if (req_write) begin
            cs_d = 1'b0; // No lane enabled: nothing to write
            rdy_d = 1'b1;
          end else begin
            oe_d = 1'b1;
            st_d = PSRC_READ;
          end
        end else begin
          cnt_d = cnt_q;
          rdy_d = 1'b1; // Ready rises on the first edge after reset
        end
      end
      PSRC_READ: begin
        // Sampling lags the pin by the two synchroniser stages
        if (cnt_q == 16'(psrc_pkg::READ_CYC + 1)) begin
          rdat_d = din_s2_q;
          rv_d = 1'b1;
          cs_d = 1'b0;
          oe_d = 1'b0;
          cnt_d = '0;
          st_d = PSRC_FLOAT;
        end
      end
      PSRC_WRITE: begin
        // Drive data only once the device has floated its outputs
        if (cnt_q == 16'(psrc_pkg::up_cyc(psrc_pkg::WE_FLOAT_DELAY_NS)))
          doe_d = 1'b1;
        if (cnt_q == 16'(psrc_pkg::WRITE_CYC)) begin
          we_d = 1'b0;
          cnt_d = '0;
          st_d = PSRC_FLOAT;
        end
      end
      PSRC_FLOAT: begin
        // Write data held one cycle past the write enable edge
        cs_d = 1'b0;
        doe_d = 1'b0;
        ub_d = 1'b0;
        lb_d = 1'b0;
        if (cnt_q == 16'(psrc_pkg::FLOAT_CYC)) begin
          cnt_d = '0;
          st_d = PSRC_DESEL;
        end
      end
      PSRC_DESEL: begin
        if (cnt_q == 16'(psrc_pkg::DESEL_CYC)) begin
          rdy_d = 1'b1;
          st_d = PSRC_IDLE;
        end
      end
      // Unused codes fall back to idle
      default: st_d = PSRC_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q <= PSRC_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      cs_q <= 1'b0;
      oe_q <= 1'b0;
      we_q <= 1'b0;
      ub_q <= 1'b0;
      lb_q <= 1'b0;
      doe_q <= 1'b0;
      rdy_q <= 1'b0;
      rv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      cs_q <= cs_d;
      oe_q <= oe_d;
      we_q <= we_d;
      ub_q <= ub_d;
      lb_q <= lb_d;
      doe_q <= doe_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
    end
  end

  // Pin outputs straight from flops, active-low pins inverted in the flop
  assign req_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rdat_q;
  assign word_address = addr_q;
  assign data_bus_out = wdat_q;
  assign data_bus_oe = doe_q;
  logic cs_n_q, cs_h_q, oe_n_q, we_n_q, ub_n_q, lb_n_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cs_n_q <= 1'b1;
      cs_h_q <= 1'b0;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ub_n_q <= 1'b1;
      lb_n_q <= 1'b1;
    end else begin
      cs_n_q <= !cs_d;
      cs_h_q <= cs_d;
      oe_n_q <= !oe_d;
      we_n_q <= !we_d;
      ub_n_q <= !ub_d;
      lb_n_q <= !lb_d;
    end
  end
  assign select_low_active_n = cs_n_q;
  assign select_high_active = cs_h_q;
  assign output_enable_n = oe_n_q;
  assign write_enable_n = we_n_q;
  assign upper_byte_select_n = ub_n_q;
  assign lower_byte_select_n = lb_n_q;

  // Helper: cycles the part has been selected
  logic [psrc_pkg::CNT_W-1:0] sel_cnt_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n || cs_n_q)
      sel_cnt_q <= '0;
    else
      sel_cnt_q <= sel_cnt_q + 16'h0001;
  end

  a_read_we_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !oe_n_q |-> we_n_q) else $error("write enable low in read");
  a_select_max_time: assert property (@(posedge sys_clk)
    disable iff (!reset_n) sel_cnt_q < 16'(SELECT_MAX))
    else $error("select held too long");
  a_desel_min_time: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $rose(cs_n_q) |-> cs_n_q [*2])
    else $error("deselect too short");
  a_addr_stable_sel: assert property (@(posedge sys_clk)
    disable iff (!reset_n) (!cs_n_q && $past(!cs_n_q)) |-> $stable(addr_q))
    else $error("address moved while selected");
  a_data_after_float: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $fell(we_n_q) |-> !doe_q [*2])
    else $error("data driven before float");
  a_write_pulse_len: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $fell(we_n_q) |-> !we_n_q [*3])
    else $error("write pulse too short");
  a_write_data_hold: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $rose(we_n_q) |-> doe_q && $stable(wdat_q))
    else $error("write data not held");
  a_write_qualified: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !we_n_q |-> !cs_n_q && (!ub_n_q || !lb_n_q))
    else $error("write without qualifiers");
  a_read_response: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $fell(oe_n_q) |-> ##7 rsp_valid)
    else $error("read answer late");
  c_read: cover property (@(posedge sys_clk) rsp_valid);
  c_write: cover property (@(posedge sys_clk) $rose(we_n_q));
  c_upper_only: cover property (@(posedge sys_clk)
    !we_n_q && ub_n_q == 1'b0 && lb_n_q == 1'b1);
endmodule

// ### tb/psrc_mem_model.sv
// Purpose: Behavioural pseudo-static RAM facing the controller
// Assumes: Slow grade timing, whole device evaluated every ns
// Notes:   Released bus shows a toggling inverse; faults are counted
`timescale 1ns/100ps
module psrc_mem_model (
  // Device pins
  input wire logic [19:0] word_address,
  input wire logic select_low_active_n,
  input wire logic select_high_active,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  // Host drive and resolved wire
  input wire logic [15:0] host_d,
  input wire logic host_oe,
  output logic [15:0] bus,
  // Fault counts
  output int clash,
  output int viol
);
  logic [15:0] mem [int];
  logic [15:0] cap_d, q, w;
  logic [1:0] lane, cap_l;
  logic sel, rd, wr, wr_q;
  logic [19:0] a_q;
  int t_acc, t_off, t_sel, t_des, t_ad, t_dat, t_wr;
  initial begin
    bus = 16'h0000;
    {clash, viol, t_acc, t_sel, t_des, t_ad, t_dat, t_wr} = '0;
    t_off = 99;
    wr_q = 1'b0;
    a_q = 20'h00000;
  end
  // One step per ns, half a ns off the clock edges so no race with flops
  always begin
    #0.5;
    sel = !select_low_active_n && select_high_active;
    lane = {!upper_byte_select_n, !lower_byte_select_n};
    rd = sel && !output_enable_n && write_enable_n && |lane;
    wr = sel && !write_enable_n && |lane;
    // Store at the edge that ends the write
    if (wr_q && !wr) begin
      if (t_wr < 60 || t_dat < 30 || t_ad < 60) viol++;
      w = mem.exists(a_q) ? mem[a_q] : 16'h0000;
      if (cap_l[1]) w[15:8] = cap_d[15:8];
      if (cap_l[0]) w[7:0] = cap_d[7:0];
      mem[a_q] = w;
    end
    if (wr) begin
      t_dat = (host_oe && host_d === cap_d) ? t_dat + 1 : 0;
      cap_d = host_d;
      cap_l = lane;
    end
    t_wr = wr ? t_wr + 1 : 0;
    t_acc = (rd && word_address === a_q) ? t_acc + 1 : 0;
    t_ad = (word_address === a_q) ? t_ad + 1 : 0;
    t_off = rd ? 0 : t_off + 1;
    t_des = sel ? 0 : t_des + 1;
    // Refresh only after a deselect longer than 5 ns
    if (t_des > 5) t_sel = 0;
    else if (sel) t_sel++;
    if (t_sel > 15000) viol++;
    if (rd) q = (t_acc >= 70) ? mem[word_address] : 16'hA5C3 ^ 16'(t_acc);
    if (host_oe && t_off < 25) clash++;
    bus = host_oe ? host_d : (t_off < 25) ? q : ~bus;
    a_q = word_address;
    wr_q = wr;
    #0.5;
  end
endmodule

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the pseudo-static RAM controller
// Assumes: Requests driven at falling edges, results checked from a queue
// Notes:   Expected words kept in a local image of the memory
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 0, reset_n = 0, req_valid = 0, req_write = 0;
  logic [19:0] req_addr = 0, word_address;
  logic [15:0] req_wdata = 0, rsp_rdata, data_bus_in, data_bus_out;
  logic [1:0] req_byte_en = 0;
  logic req_ready, rsp_valid, select_low_active_n, select_high_active;
  logic output_enable_n, write_enable_n, data_bus_oe;
  logic upper_byte_select_n, lower_byte_select_n;
  int fail_count = 0, tests_run = 0, seed = 93, cyc = 0, clash, viol;
  logic [15:0] em [int];
  logic [15:0] exp_q [$];
  psrc_ctrl u_psrc_ctrl (.sys_clk, .reset_n, .req_valid, .req_write,
    .req_addr, .req_wdata, .req_byte_en, .req_ready, .rsp_valid, .rsp_rdata,
    .word_address, .select_low_active_n, .select_high_active,
    .output_enable_n, .write_enable_n, .upper_byte_select_n,
    .lower_byte_select_n, .data_bus_in, .data_bus_out, .data_bus_oe);
  psrc_mem_model u_psrc_mem_model (.word_address, .select_low_active_n,
    .select_high_active, .output_enable_n, .write_enable_n,
    .upper_byte_select_n, .lower_byte_select_n, .host_d(data_bus_out),
    .host_oe(data_bus_oe), .bus(data_bus_in), .clash, .viol);
  always #10 sys_clk = ~sys_clk;
  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request, held until taken; the note is made at the taking edge
  task automatic access(input logic wr, input logic [19:0] a,
                        input logic [15:0] d, input logic [1:0] be);
    @(negedge sys_clk);
    {req_valid, req_write, req_addr} = {1'b1, wr, a};
    {req_wdata, req_byte_en} = {d, be};
    // Ready is a flop: high at a falling edge means taken at the next rise
    while (req_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    if (!wr) exp_q.push_back(em[a]);
    if (wr && be[1]) em[a][15:8] = d[15:8];
    if (wr && be[0]) em[a][7:0] = d[7:0];
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // Read results taken off the queue in order
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      check(16'(exp_q.size() > 0), 16'h0001);
      if (exp_q.size() > 0) check(rsp_rdata, exp_q.pop_front());
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    check(16'({select_low_active_n, select_high_active, write_enable_n}),
          16'h0005);
    for (int i = 0; i < 8; i++) access(1, 20'(i), 16'($random(seed)), 2'b11);
    for (int i = 0; i < 16; i++)
      access(1, 20'(i % 8), 16'($random(seed)), 2'(i));
    for (int i = 0; i < 8; i++) access(0, 20'(i), 16'h0000, 2'b11);
    em[20'hFFFFF] = 16'h0000;
    access(1, 20'hFFFFF, 16'hA55A, 2'b11);
    access(0, 20'hFFFFF, 16'h0000, 2'b11);
    for (int i = 0; i < 24; i++)
      access(1'($random(seed)), 20'($random(seed) & 7), 16'($random(seed)),
             2'($random(seed)));
    repeat (20) @(negedge sys_clk);
    check(16'(exp_q.size()), 16'h0000);
    check(16'(clash), 16'h0000);
    check(16'(viol), 16'h0000);
    end_sim();
  end
endmodule
